// ==== utopia_master_pkg.sv ====
// Shared constants, register map and state codes for the cell master.
// Assumes a 200 MHz system clock and 8-bit software register port.
package utopia_master_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Cell layout
  localparam int CELL_DEPTH = 53;
  localparam logic [5:0] CELL_BYTES = 6'(CELL_DEPTH);
  localparam logic [5:0] UDF_INDEX = 6'h04;
  localparam logic [5:0] PAYLOAD_START = 6'h05;
  localparam logic [2:0] HDR_BYTES = 3'h4;
  localparam logic [2:0] UDF_BYTES = 3'h1;
  localparam logic [2:0] RX_GROUP = 3'h4;
  localparam logic [2:0] GROUP_MAX = 3'h4;
  localparam logic [7:0] UDF_FILL = 8'h00;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CLKDIV = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_TXCMD = 8'h03;
  localparam logic [7:0] TXMEM_BASE = 8'h40;
  localparam logic [7:0] RXMEM_BASE = 8'h80;

  // Field positions and reset values
  localparam int CTRL_MPHY = 0;
  localparam int CTRL_SEM = 1;
  localparam int CTRL_GRP_LSB = 2;
  localparam int CTRL_GRP_MSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h10;
  localparam int ST_RXDONE = 0;
  localparam int ST_TXPEND = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_RXCAV = 3;
  localparam int ST_TXCAV = 4;
  localparam int ST_SOCOK = 5;
  localparam int ST_PHY_LSB = 6;
  localparam int ST_PHY_MSB = 7;
  localparam int TXCMD_GO = 7;

  // Interface clock: 200 MHz system, 25 MHz ceiling
  localparam int SYS_MHZ = 200;
  localparam int LINK_MAX_MHZ = 25;
  localparam logic [7:0] MIN_HALF = 8'((SYS_MHZ + 2 * LINK_MAX_MHZ - 1) / (2 * LINK_MAX_MHZ));
  localparam logic [7:0] CLKDIV_RESET = 8'h08;

  // Spacing figures
  localparam logic [5:0] RX_TO_TX_SYS = 6'h32;
  localparam logic [5:0] TX_TO_RX_SYS = 6'h14;
  localparam logic [5:0] TX_TO_HDR_SYS = 6'h04;
  localparam logic [5:0] SINCE_MAX = 6'h3f;
  localparam logic [3:0] GAP_CLKS = 4'h4;
  localparam logic [3:0] SEL_SETUP_CLKS = 4'h3;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SELECT = 2'b01,
    S_GROUP = 2'b10,
    S_GAP = 2'b11
  } st_t;

endpackage : utopia_master_pkg

// ==== link_tick_if.sv ====
// Edge pulses of the generated interface clock.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface link_tick_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport snk (input rise, input fall);
endinterface : link_tick_if

// ==== utopia_clk_div.sv ====
// Divider that makes the interface clock and its edge pulses.
// Assumes half_period is at least one and only changes between cells.
`timescale 1ns/1ps
module utopia_clk_div (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Asynchronous reset, high
  input wire logic [7:0] half_period, // System cycles per half period
  output logic clk_out, // Interface clock
  link_tick_if.src tick // Edge pulses, one cycle each
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_clk;
  logic next_rise;
  logic next_fall;

  // Toggle after each half period, flag the edge
  always_comb
  begin
    next_cnt = cnt + 8'h01;
    next_clk = clk_out;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (cnt >= half_period - 8'h01)
    begin
      next_cnt = 8'h00;
      next_clk = ~clk_out;
      next_rise = ~clk_out;
      next_fall = clk_out;
    end
  end

  // Divider registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt <= 8'h00;
      clk_out <= 1'b0;
      tick.rise <= 1'b0;
      tick.fall <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      clk_out <= next_clk;
      tick.rise <= next_rise;
      tick.fall <= next_fall;
    end
  end

endmodule : utopia_clk_div

// ==== utopia_cell_master.sv ====
// Cell-level transfer master for a UTOPIA level 1 link, one to four PHYs.
// Assumes link inputs are asynchronous to sys_clk; software drives reg port.
// Notes on behaviour
// [R01] Master of an 8-bit bidirectional link, interface clock at most 25 MHz.
// [R02] Either cell-available input raises a service request; receive only while rx_done is clear, transmit only while a cell is pending.
// [R03] PHY moves a whole cell once it signals cell available.
// [R04] Receive cell goes as 4-octet header, 1 UDF octet, twelve 4-octet groups.
// [R05] Receive enable per group; bus and start-of-cell sampled from next cycle.
// [R06] Receive cell-available ignored while a receive cell is moving.
// [R07] PHY may raise receive cell-available early and holds it until next cell.
// [R08] Receive requests served before transmit requests.
// [R09] Transmit: enable, start-of-cell, parity, data; payload groups 1 to 4 octets.
// [R10] No header check computed; UDF octet sent as zero.
// [R11] Data bus and start-of-cell driven only while transmit enable is active.
// [R12] Transmit cell-available not looked at during a transmit cell.
// [R13] Up to four PHYs, 2-bit request address in, 2-bit select out.
// [R14] Outside logic raises transmit cell-available only when all PHYs accept.
// [R15] Multi-PHY receive waits while the port write semaphore is set.
// [R16] Outside logic holds the request address until receive enable.
// [R17] PHY select stays valid until the cell transfer ends.
// [R18] Multi-PHY transmit: select first, enable several interface clocks later.
// [R19] Outside priority logic presents the highest requesting PHY number.
// [R20] Gap of at least four interface clocks between groups of a cell.
// [R21] 50 cycles receive-to-transmit, 20 cycles transmit-to-receive spacing.
// [R22] 4 cycles from transmit enable negation to next header group.
// [R23] Software sets up the PHY addressing pins before multi-PHY use.
// [R24] Cell-available assertions recognised within two clock cycles.
// [R25] PHY select settles at least one clock before any enable.
// [R26] Cell-available and request address pass a two-stage synchroniser.
`timescale 1ns/1ps
module utopia_cell_master (
  input wire logic sys_clk, // 200 MHz system clock
  input wire logic sys_rst, // Asynchronous reset, high
  input wire logic [utopia_master_pkg::ADDR_W-1:0] reg_addr, // Register address
  input wire logic [utopia_master_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [utopia_master_pkg::DATA_W-1:0] reg_rdata, // Read data, next cycle
  output logic interface_clock_out, // Link clock to the PHYs
  input wire logic [7:0] cell_data_in, // Cell data bus, pin level
  output logic [7:0] cell_data_out, // Cell data bus, driven value
  output logic cell_data_oe, // Cell data bus drive enable
  input wire logic soc_in, // Start-of-cell pin level
  output logic soc_out, // Start-of-cell driven value
  output logic soc_oe, // Start-of-cell drive enable
  output logic tx_parity, // Odd parity of driven octet
  output logic tx_enb_n, // Transmit enable, low active
  output logic rx_enb_n, // Receive enable, low active
  input wire logic tx_cav, // Transmit cell available
  input wire logic rx_cav, // Receive cell available
  input wire logic [1:0] phy_request_address, // Requesting PHY number
  output logic [1:0] phy_select, // Selected PHY number
  output logic service_request // Cell service pending
);
  import utopia_master_pkg::*;

  localparam int SYNC_W = 13;

  st_t state;
  st_t next_state;
  logic dir_tx;
  logic next_dir_tx;
  logic [5:0] byte_idx;
  logic [5:0] next_byte_idx;
  logic [2:0] grp_left;
  logic [2:0] next_grp_left;
  logic [3:0] wait_cnt;
  logic [3:0] next_wait_cnt;
  logic [5:0] since_rx;
  logic [5:0] next_since_rx;
  logic [5:0] since_tx;
  logic [5:0] next_since_tx;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] clkdiv;
  logic [7:0] next_clkdiv;
  logic rx_done;
  logic next_rx_done;
  logic tx_pending;
  logic next_tx_pending;
  logic [1:0] tx_target;
  logic [1:0] next_tx_target;
  logic [1:0] rx_phy;
  logic [1:0] next_rx_phy;
  logic soc_ok;
  logic next_soc_ok;
  logic drive_en;
  logic next_drive_en;
  logic [7:0] next_data_out;
  logic next_soc_out;
  logic next_parity;
  logic next_tx_enb_n;
  logic next_rx_enb_n;
  logic [1:0] next_phy_select;
  logic next_service_request;
  logic [7:0] next_rdata;
  logic rx_wr;
  logic [7:0] tx_mem [CELL_DEPTH];
  logic [7:0] rx_mem [CELL_DEPTH];
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic rx_cav_s;
  logic tx_cav_s;
  logic rx_soc_s;
  logic [1:0] phy_req_s;
  logic [7:0] data_s;
  logic rx_want;
  logic tx_ok;
  logic mphy;

  link_tick_if tick ();

  // Interface clock generator
  utopia_clk_div u_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .half_period(clkdiv),
    .clk_out(interface_clock_out),
    .tick(tick.src)
  );

  // Payload group size, clipped to what is left of the cell
  function automatic logic [2:0] grp_size(input logic [5:0] idx, input logic tx,
                                          input logic [2:0] cfg);
    logic [5:0] left;
    logic [2:0] want;
    left = CELL_BYTES - idx;
    want = (cfg == 3'h0) ? 3'h1 : ((cfg > GROUP_MAX) ? GROUP_MAX : cfg);
    if (!tx)
      want = RX_GROUP;
    if (idx < UDF_INDEX)
      grp_size = HDR_BYTES;
    else if (idx == UDF_INDEX)
      grp_size = UDF_BYTES;
    else if (left < 6'(want))
      grp_size = left[2:0];
    else
      grp_size = want;
  endfunction : grp_size

  // Octet to send; the UDF slot carries a fill value
  function automatic logic [7:0] tx_byte(input logic [5:0] idx, input logic [7:0] mem_val);
    tx_byte = (idx == UDF_INDEX) ? UDF_FILL : mem_val; // [R10]
  endfunction : tx_byte

  // Two-stage synchroniser for every link input
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {cell_data_in, soc_in, phy_request_address, tx_cav, rx_cav}; // [R26]
      sync_b <= sync_a; // [R24]
    end
  end

  // Synchronised views
  assign rx_cav_s = sync_b[0];
  assign tx_cav_s = sync_b[1];
  assign phy_req_s = sync_b[3:2];
  assign rx_soc_s = sync_b[4];
  assign data_s = sync_b[12:5];
  assign mphy = ctrl[CTRL_MPHY];
  assign soc_oe = drive_en;
  assign cell_data_oe = drive_en;

  // Receive request waits only for a free buffer; the semaphore gates it in S_IDLE in multi-PHY mode
  assign rx_want = rx_cav_s && !rx_done;
  assign tx_ok = tx_pending && tx_cav_s && !rx_want && since_rx >= RX_TO_TX_SYS
                 && since_tx >= TX_TO_HDR_SYS; // [R08] [R21] [R22]

  // Next-state logic: register writes first so the transfer engine's sets win
  always_comb
  begin
    next_state = state;
    next_dir_tx = dir_tx;
    next_byte_idx = byte_idx;
    next_grp_left = grp_left;
    next_wait_cnt = wait_cnt;
    next_since_rx = (since_rx == SINCE_MAX) ? since_rx : since_rx + 6'h01;
    next_since_tx = (since_tx == SINCE_MAX) ? since_tx : since_tx + 6'h01;
    next_ctrl = ctrl;
    next_clkdiv = clkdiv;
    next_rx_done = rx_done;
    next_tx_pending = tx_pending;
    next_tx_target = tx_target;
    next_rx_phy = rx_phy;
    next_soc_ok = soc_ok;
    next_drive_en = drive_en;
    next_data_out = cell_data_out;
    next_soc_out = soc_out;
    next_parity = tx_parity;
    next_tx_enb_n = tx_enb_n;
    next_rx_enb_n = rx_enb_n;
    next_phy_select = phy_select;
    next_rdata = '0;
    rx_wr = 1'b0;
    next_service_request = rx_want || (tx_pending && tx_cav_s); // [R02]
    if (reg_wr)
    begin
      if (reg_addr == REG_CTRL)
        next_ctrl = reg_wdata;
      else if (reg_addr == REG_CLKDIV)
        next_clkdiv = (reg_wdata < MIN_HALF) ? MIN_HALF : reg_wdata; // [R01]
      else if (reg_addr == REG_STATUS && reg_wdata[ST_RXDONE])
        next_rx_done = 1'b0;
      else if (reg_addr == REG_TXCMD && reg_wdata[TXCMD_GO] && !tx_pending)
      begin
        next_tx_pending = 1'b1;
        next_tx_target = reg_wdata[1:0];
      end
    end
    case (state)
      S_IDLE:
      begin
        // Cell-available only starts a cell here, never mid-cell
        if (rx_want && since_tx >= TX_TO_RX_SYS && !(mphy && ctrl[CTRL_SEM])) // [R06] [R15]
        begin
          next_state = S_SELECT;
          next_dir_tx = 1'b0;
          next_phy_select = mphy ? phy_req_s : 2'b00; // [R13] [R15]
          next_rx_phy = mphy ? phy_req_s : 2'b00;
          next_byte_idx = 6'h00;
          next_wait_cnt = SEL_SETUP_CLKS;
        end
        else if (tx_ok) // [R12]
        begin
          next_state = S_SELECT;
          next_dir_tx = 1'b1;
          next_phy_select = mphy ? tx_target : 2'b00; // [R18]
          next_byte_idx = 6'h00;
          next_wait_cnt = SEL_SETUP_CLKS;
        end
      end
      S_SELECT, S_GAP:
      begin
        // Enable only after the select or gap wait has run out
        if (tick.fall)
        begin
          if (wait_cnt != 4'h1)
            next_wait_cnt = wait_cnt - 4'h1; // [R18] [R20] [R25]
          else
          begin
            next_state = S_GROUP;
            next_grp_left = grp_size(byte_idx, dir_tx, ctrl[CTRL_GRP_MSB:CTRL_GRP_LSB]); // [R04]
            if (dir_tx)
            begin
              next_tx_enb_n = 1'b0; // [R09]
              next_drive_en = 1'b1; // [R11]
              next_data_out = tx_byte(byte_idx, tx_mem[byte_idx]);
              next_soc_out = (byte_idx == 6'h00);
              next_parity = ~^tx_byte(byte_idx, tx_mem[byte_idx]);
              next_byte_idx = byte_idx + 6'h01;
              next_grp_left = grp_size(byte_idx, dir_tx, ctrl[CTRL_GRP_MSB:CTRL_GRP_LSB]) - 3'h1;
            end
            else
              next_rx_enb_n = 1'b0; // [R05]
          end
        end
      end
      S_GROUP:
      begin
        if (tick.fall && dir_tx)
        begin
          if (grp_left == 3'h0)
          begin
            next_tx_enb_n = 1'b1;
            next_drive_en = 1'b0; // [R11]
            next_soc_out = 1'b0;
            next_since_tx = 6'h00;
            next_wait_cnt = GAP_CLKS; // [R20]
            next_state = (byte_idx == CELL_BYTES) ? S_IDLE : S_GAP;
            if (byte_idx == CELL_BYTES)
              next_tx_pending = 1'b0;
          end
          else
          begin
            next_data_out = tx_byte(byte_idx, tx_mem[byte_idx]); // [R09]
            next_soc_out = 1'b0;
            next_parity = ~^tx_byte(byte_idx, tx_mem[byte_idx]);
            next_byte_idx = byte_idx + 6'h01;
            next_grp_left = grp_left - 3'h1;
          end
        end
        else if (tick.fall)
        begin
          // Sample one octet per interface clock after the enable
          rx_wr = 1'b1; // [R05]
          if (byte_idx == 6'h00)
            next_soc_ok = rx_soc_s;
          next_byte_idx = byte_idx + 6'h01;
          next_grp_left = grp_left - 3'h1;
          if (grp_left == 3'h1)
          begin
            next_rx_enb_n = 1'b1;
            next_since_rx = 6'h00;
            next_wait_cnt = GAP_CLKS; // [R20]
            next_state = (byte_idx + 6'h01 == CELL_BYTES) ? S_IDLE : S_GAP; // [R04]
            if (byte_idx + 6'h01 == CELL_BYTES)
              next_rx_done = 1'b1;
          end
        end
      end
      default:
        next_state = S_IDLE;
    endcase
    if (reg_rd)
    begin
      if (reg_addr == REG_CTRL)
        next_rdata = ctrl;
      else if (reg_addr == REG_CLKDIV)
        next_rdata = clkdiv;
      else if (reg_addr == REG_STATUS)
      begin
        next_rdata[ST_RXDONE] = rx_done;
        next_rdata[ST_TXPEND] = tx_pending;
        next_rdata[ST_BUSY] = (state != S_IDLE);
        next_rdata[ST_RXCAV] = rx_cav_s;
        next_rdata[ST_TXCAV] = tx_cav_s;
        next_rdata[ST_SOCOK] = soc_ok;
        next_rdata[ST_PHY_MSB:ST_PHY_LSB] = rx_phy;
      end
      else if (reg_addr >= TXMEM_BASE && reg_addr < TXMEM_BASE + 8'(CELL_BYTES))
        next_rdata = tx_mem[6'(reg_addr - TXMEM_BASE)];
      else if (reg_addr >= RXMEM_BASE && reg_addr < RXMEM_BASE + 8'(CELL_BYTES))
        next_rdata = rx_mem[6'(reg_addr - RXMEM_BASE)];
    end
  end

  // Cell buffers
  always_ff @(posedge sys_clk)
  begin
    if (reg_wr && reg_addr >= TXMEM_BASE && reg_addr < TXMEM_BASE + 8'(CELL_BYTES))
      tx_mem[6'(reg_addr - TXMEM_BASE)] <= reg_wdata;
    if (rx_wr)
      rx_mem[byte_idx] <= data_s;
  end

  // Control, status and pin registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= S_IDLE;
      dir_tx <= 1'b0;
      byte_idx <= 6'h00;
      grp_left <= 3'h0;
      wait_cnt <= 4'h0;
      since_rx <= SINCE_MAX;
      since_tx <= SINCE_MAX;
      ctrl <= CTRL_RESET;
      clkdiv <= CLKDIV_RESET;
      rx_done <= 1'b0;
      tx_pending <= 1'b0;
      tx_target <= 2'b00;
      rx_phy <= 2'b00;
      soc_ok <= 1'b0;
      drive_en <= 1'b0;
      cell_data_out <= 8'h00;
      soc_out <= 1'b0;
      tx_parity <= 1'b0;
      tx_enb_n <= 1'b1;
      rx_enb_n <= 1'b1;
      phy_select <= 2'b00;
      service_request <= 1'b0;
      reg_rdata <= '0;
    end
    else
    begin
      state <= next_state;
      dir_tx <= next_dir_tx;
      byte_idx <= next_byte_idx;
      grp_left <= next_grp_left;
      wait_cnt <= next_wait_cnt;
      since_rx <= next_since_rx;
      since_tx <= next_since_tx;
      ctrl <= next_ctrl;
      clkdiv <= next_clkdiv;
      rx_done <= next_rx_done;
      tx_pending <= next_tx_pending;
      tx_target <= next_tx_target;
      rx_phy <= next_rx_phy;
      soc_ok <= next_soc_ok;
      drive_en <= next_drive_en;
      cell_data_out <= next_data_out;
      soc_out <= next_soc_out;
      tx_parity <= next_parity;
      tx_enb_n <= next_tx_enb_n;
      rx_enb_n <= next_rx_enb_n;
      phy_select <= next_phy_select; // [R17]
      service_request <= next_service_request;
      reg_rdata <= next_rdata;
    end
  end

  // Checks on the link side
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  enb_exclusive_a : assert property (rx_enb_n || tx_enb_n) // [R08]
    else $error("both enables active");
  bus_drive_a : assert property (cell_data_oe |-> !tx_enb_n && soc_oe) // [R11]
    else $error("bus driven without transmit enable");
  udf_zero_a : assert property (cell_data_oe && byte_idx == PAYLOAD_START // [R10]
    |-> cell_data_out == UDF_FILL)
    else $error("UDF octet not zero");
  rx_to_tx_a : assert property ($fell(tx_enb_n) |-> since_rx >= RX_TO_TX_SYS) // [R21]
    else $error("receive to transmit spacing short");
  tx_to_rx_a : assert property ($fell(rx_enb_n) |-> since_tx >= TX_TO_RX_SYS) // [R21]
    else $error("transmit to receive spacing short");
  hdr_space_a : assert property ($fell(tx_enb_n) && soc_out |-> since_tx >= TX_TO_HDR_SYS) // [R22]
    else $error("header group follows too soon");
  sel_hold_a : assert property (state != S_IDLE && $past(state) != S_IDLE // [R17]
    |-> $stable(phy_select))
    else $error("select changed mid cell");
  sel_lead_a : assert property ($fell(rx_enb_n) || $fell(tx_enb_n) |-> $stable(phy_select)) // [R25]
    else $error("select not ahead of enable");
  cav_seen_a : assert property (rx_cav [*3] |-> rx_cav_s) // [R24]
    else $error("receive cell available not seen");
  rx_first_a : assert property (state == S_IDLE && rx_want && tx_pending // [R08]
    |=> !(state == S_SELECT && dir_tx))
    else $error("transmit started over receive");
  sem_wait_a : assert property (state == S_IDLE && mphy && ctrl[CTRL_SEM] // [R15]
    |=> !(state == S_SELECT && !dir_tx))
    else $error("receive started with semaphore set");

  rx_cell_c : cover property ($rose(rx_done));
  tx_cell_c : cover property ($fell(tx_pending));
  mphy_sel_c : cover property (state == S_SELECT && phy_select != 2'b00);

endmodule : utopia_cell_master

// ==== utopia_phy_model.sv ====
// Behavioural PHY with generated receive cells and a one-cell transmit store, on the far side of the link.
// Assumes it is clocked by the master's interface clock output.
`timescale 1ns/1ps
module utopia_phy_model (
  input wire logic link_clk, // Interface clock from master
  input wire logic rx_enb_n, // Receive enable, low active
  input wire logic tx_enb_n, // Transmit enable, low active
  input wire logic [7:0] tx_data, // Octet driven by master
  input wire logic tx_soc, // Start-of-cell from master
  input wire logic tx_par, // Parity from master
  input wire logic rx_have, // Bench: a cell is ready
  input wire logic tx_room, // Bench: room for a cell
  output logic rx_cav, // Receive cell available
  output logic tx_cav, // Transmit cell available
  output logic [7:0] rx_data, // Octet driven to master
  output logic rx_soc // Start-of-cell to master
);
  logic [5:0] rx_idx = 0;
  logic [5:0] tx_idx = 0;
  logic [7:0] tx_mem [0:52];
  int bad = 0;
  // Whole cell ready once flagged, held by the bench
  assign rx_cav = rx_have;
  assign tx_cav = tx_room;
  initial rx_data = 8'h00;
  initial rx_soc = 1'b0;
  // Octet moves on each rising edge with enable low
  always @(posedge link_clk)
  begin
    if (!rx_enb_n)
    begin
      rx_data <= 8'hc0 ^ {2'b00, rx_idx};
      rx_soc <= (rx_idx == 6'h00);
      rx_idx <= (rx_idx == 6'd52) ? 6'h00 : rx_idx + 6'h01;
    end
    else
    begin
      rx_data <= ~rx_data; // Released bus toggles
      rx_soc <= ~rx_soc;
    end
    if (!tx_enb_n)
    begin
      tx_mem[tx_idx] <= tx_data;
      if (tx_soc !== (tx_idx == 6'h00) || tx_par !== ~^tx_data)
        bad++;
      tx_idx <= (tx_idx == 6'd52) ? 6'h00 : tx_idx + 6'h01;
    end
  end
endmodule : utopia_phy_model

// ==== utopia_l1_cell_master_tb.sv ====
// Self-checking bench for the cell master: register port and link.
// Assumes the PHY model file and the design files are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module utopia_l1_cell_master_tb;
  import utopia_master_pkg::*;
  logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rx_have = 0, tx_room = 1;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d, dout, phy_data;
  logic [1:0] req = 0, phy_select, exp_sel = 0, psel;
  logic clk_out, oe, soc_out, soc_oe, soc_rx, par, tx_enb_n, rx_enb_n, rx_cav, tx_cav, srq;
  logic prx = 1, ptx = 1;
  int err_count = 0, compares = 0, rx_groups = 0, tx_groups = 0, first_kind = 0, k;
  int since_rx = 999, since_tx = 999, sp_bad = 0, sel_bad = 0, oe_bad = 0;
  wire [7:0] bus = oe ? dout : phy_data;
  wire soc_w = soc_oe ? soc_out : soc_rx;
  utopia_cell_master i_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .interface_clock_out(clk_out), .cell_data_in(bus), .cell_data_out(dout),
    .cell_data_oe(oe), .soc_in(soc_w), .soc_out, .soc_oe, .tx_parity(par), .tx_enb_n,
    .rx_enb_n, .tx_cav, .rx_cav, .phy_request_address(req), .phy_select,
    .service_request(srq));
  utopia_phy_model i_phy (.link_clk(clk_out), .rx_enb_n, .tx_enb_n, .tx_data(dout),
    .tx_soc(soc_out), .tx_par(par), .rx_have, .tx_room, .rx_cav, .tx_cav,
    .rx_data(phy_data), .rx_soc(soc_rx));
  // System clock
  initial forever #2.5 sys_clk = ~sys_clk;
  // Link monitor: group counts, spacing, select and drive enables
  always @(posedge sys_clk)
  begin
    if (!sys_rst)
    begin
      if (!rx_enb_n && prx)
      begin
        rx_groups++;
        if (first_kind == 0) first_kind = 1;
        if (since_tx < 20) sp_bad++;
      end
      if (!tx_enb_n && ptx)
      begin
        tx_groups++;
        if (first_kind == 0) first_kind = 2;
        if (since_rx < 50 || since_tx < 4) sp_bad++;
      end
      since_rx = !rx_enb_n ? 0 : since_rx + 1;
      since_tx = !tx_enb_n ? 0 : since_tx + 1;
      if ((!rx_enb_n || !tx_enb_n) && (phy_select !== exp_sel || psel !== exp_sel))
        sel_bad++;
      if (oe !== ~tx_enb_n || soc_oe !== oe) oe_bad++;
      prx = rx_enb_n;
      ptx = tx_enb_n;
      psel = phy_select;
    end
  end
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask : rd
  task wait_st(input int b, input logic v);
    int n;
    n = 0;
    rd(REG_STATUS);
    while (d[b] !== v && n < 4000)
    begin
      rd(REG_STATUS);
      n++;
    end
    `CHK(d[b], v)
  endtask : wait_st
  // Drops the request once the first group of the cell began
  task rx_start;
    int n;
    n = 0;
    while (rx_groups == 0 && n < 4000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (rx_groups == 0)
      err_count++;
    rx_have <= 0;
  endtask : rx_start
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // Watchdog
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    err_count++;
    report_and_stop();
  end
  // Tests
  initial
  begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 0;
    rd(REG_CTRL);
    `CHK(d, CTRL_RESET)
    rd(REG_CLKDIV);
    `CHK(d, CLKDIV_RESET)
    rd(8'h3f);
    `CHK(d, 8'h00)
    wr(REG_CLKDIV, 8'h02);
    rd(REG_CLKDIV);
    `CHK(d, 8'h04)
    wr(REG_CLKDIV, 8'h08);
    $display("test regs done");
    rx_have <= 1;
    repeat (6) @(posedge sys_clk);
    `CHK(srq, 1'b1)
    wait_st(ST_RXDONE, 1'b1);
    `CHK(rx_groups, 14)
    for (k = 0; k < 53; k++)
    begin
      rd(RXMEM_BASE + 8'(k));
      `CHK(d, 8'hc0 ^ 8'(k))
    end
    rd(REG_STATUS);
    `CHK(d[ST_SOCOK], 1'b1)
    $display("test receive done");
    rx_have <= 0;
    tx_room <= 0;
    wr(REG_STATUS, 8'h01);
    for (k = 0; k < 53; k++)
      wr(TXMEM_BASE + 8'(k), (k == 4) ? 8'hff : 8'h60 + 8'(k));
    wr(REG_CTRL, 8'h0c);
    wr(REG_TXCMD, 8'h80);
    rx_groups = 0;
    first_kind = 0;
    rx_have <= 1;
    tx_room <= 1;
    rx_start();
    wait_st(ST_TXPEND, 1'b0);
    repeat (100) @(posedge sys_clk);
    `CHK(first_kind, 1)
    `CHK(rx_groups, 14)
    `CHK(tx_groups, 18)
    for (k = 0; k < 53; k++)
      `CHK(i_phy.tx_mem[k], (k == 4) ? UDF_FILL : 8'h60 + 8'(k))
    `CHK(i_phy.bad, 0)
    $display("test transmit done");
    wr(REG_STATUS, 8'h01);
    wr(REG_CTRL, 8'h13);
    req <= 2'b10;
    exp_sel = 2'b10;
    rx_groups = 0;
    rx_have <= 1;
    repeat (400) @(posedge sys_clk);
    `CHK(rx_groups, 0)
    wr(REG_CTRL, 8'h1d);
    rx_start();
    wait_st(ST_RXDONE, 1'b1);
    rd(REG_STATUS);
    `CHK(d[ST_PHY_MSB:ST_PHY_LSB], 2'b10)
    repeat (100) @(posedge sys_clk);
    exp_sel = 2'b01;
    wr(REG_TXCMD, 8'h81);
    wait_st(ST_TXPEND, 1'b0);
    repeat (100) @(posedge sys_clk);
    `CHK(tx_groups, 32)
    `CHK(i_phy.bad, 0)
    `CHK(sel_bad, 0)
    `CHK(sp_bad, 0)
    `CHK(oe_bad, 0)
    $display("test multi-phy done");
    report_and_stop();
  end
endmodule : utopia_l1_cell_master_tb
